/* core/tdt_top.sv */
// Three-channel 16-bit down timer with two shared prescalers and port outputs.
// Assumes a single-cycle register master on clk_sys; read data appear one
// cycle after the read strobe. Pins are driven from flip-flops.
// Assumes rst_n is already synchronous to clk_sys. Every slower rate inside is
// a one-cycle enable, so the whole block sits in the one clock domain and no
// signal needs a synchroniser.
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps

module tdt_top (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [7:0] addr,
    input wire logic [15:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [15:0] rd_data,
    output logic [2:0] timer_out,
    output logic [2:0] timer_out_en
);
    // Divide-by-eight phase counter for the timer input clock enable.
    // Three bits wrap naturally at eight, so no compare-and-clear is needed.
    logic [2:0] tclk_cnt;
    // One-cycle enable at the timer input clock rate.
    logic tclk_en;
    // Prescaler control registers.
    logic [15:0] ps_ctrl [2];
    // Prescaler down counters.
    logic [7:0] ps_cnt [2];
    // Divider outputs feeding the prescaler counters.
    logic [1:0] ps_div_tick;
    // Prescaler output enables.
    logic [1:0] ps_tick;
    // Prescaler register write selects.
    logic [1:0] ps_wr;
    // Sticky status flags, one per channel.
    // They are masked at the source: an underflow with interrupts off sets nothing.
    logic [2:0] irq_flag;
    // Per-channel read contributions, zero unless addressed.
    logic [15:0] ch_rdata [3];
    // Read contributions of prescalers and status.
    logic [15:0] com_rdata;
    // Whether any register answers the address.
    logic [2:0] ch_hit;
    logic com_hit;
    // Combined read value presented one cycle later.
    logic [15:0] next_rd_data;

    // Timer input clock enable: one pulse every eight bus clocks. An enable is
    // used instead of a divided clock so that no second clock domain appears and
    // the register port can touch every counter without any crossing.
    assign tclk_en = (tclk_cnt == tdt_pkg::TCLK_LAST);

    // Free-running phase counter for the timer input clock.
    // It is never reloaded by software, so the first enable comes seven cycles after reset.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            tclk_cnt <= 3'h0;
        end else begin
            tclk_cnt <= tclk_cnt + 3'h1;
        end
    end

    // Write selects for the two prescaler registers.
    // The decode is exact: a write anywhere else leaves both prescalers alone.
    assign ps_wr[0] = wr_en && (addr == tdt_pkg::OFF_PS0);
    assign ps_wr[1] = wr_en && (addr == tdt_pkg::OFF_PS1);

    // The two shared prescalers, each a divider followed by a load counter.
    // Both run from the same timer clock enable; channels pick one of them, or
    // their own divider, through the source field of their control register.
    for (genvar p = 0; p < 2; p++) begin : g_ps
        tdt_div u_div (
            .clk_sys(clk_sys),
            .rst_n(rst_n),
            .tick_in(tclk_en),
            .ratio(ps_ctrl[p][tdt_pkg::PS_DIV_HI:tdt_pkg::PS_DIV_LO]),
            .tick_out(ps_div_tick[p])
        );

        // The prescaler fires on the divided tick that finds its counter at zero.
        // With load zero the counter stays at zero and every divided tick passes.
        assign ps_tick[p] = ps_div_tick[p] && (ps_cnt[p] == 8'h00);

        // Control register; reserved bits are never stored, so they read zero.
        always_ff @(posedge clk_sys) begin
            if (!rst_n) begin
                ps_ctrl[p] <= tdt_pkg::RST_REG;
            end else if (ps_wr[p]) begin
                ps_ctrl[p] <= wr_data & tdt_pkg::PS_MASK;
            end
        end

        // Load counter: N+1 divided ticks per output pulse. A register write
        // restarts the count so a new ratio takes effect cleanly.
        // A write costs at most one irregular period; the old phase is not kept.
        always_ff @(posedge clk_sys) begin
            if (!rst_n) begin
                ps_cnt[p] <= 8'h00;
            end else if (ps_wr[p]) begin
                ps_cnt[p] <= wr_data[tdt_pkg::PS_LOAD_HI:tdt_pkg::PS_LOAD_LO];
            end else if (ps_div_tick[p]) begin
                if (ps_cnt[p] == 8'h00) begin
                    ps_cnt[p] <= ps_ctrl[p][tdt_pkg::PS_LOAD_HI:tdt_pkg::PS_LOAD_LO];
                end else begin
                    ps_cnt[p] <= ps_cnt[p] - 8'h01;
                end
            end
        end
    end

    // The three timer channels.
    // Each one is a copy of the same logic; only the base address differs.
    for (genvar i = 0; i < tdt_pkg::NCH; i++) begin : g_ch
        // Base byte address of this channel's register group.
        localparam logic [7:0] BASE = tdt_pkg::CH_STRIDE * 8'(i);

        // Stored load value.
        logic [15:0] load;
        // Current count.
        logic [15:0] cnt;
        // Control register.
        logic [15:0] ctrl;
        // Port output control register.
        logic [15:0] port;
        // Set when a single-mode countdown has stopped at zero.
        // It is cleared only by a load write.
        logic halted;
        // Held high from an underflow until the next count step; a single-mode halt keeps it high.
        logic uf_level;
        // Toggle state for the toggle output mode.
        logic tog;
        // Output of the channel's own divider.
        logic div_tick;
        // Selected count enable.
        logic tick;
        // Counting step this cycle.
        logic step;
        // Underflow event this cycle.
        logic uf;
        // Register write selects.
        logic wr_load;
        logic wr_ctrl;
        logic wr_clr;
        logic wr_port;
        // Load writes that go straight into the counter.
        logic force_load;
        // Pin value that the output mode asks for.
        logic next_pin;
        // Field views.
        logic [1:0] src;
        logic [1:0] omode;
        logic single;

        assign src = ctrl[tdt_pkg::CTRL_SRC_HI:tdt_pkg::CTRL_SRC_LO];
        assign omode = port[tdt_pkg::PORT_OMODE_HI:tdt_pkg::PORT_OMODE_LO];
        assign single = ctrl[tdt_pkg::CTRL_MODE];

        // Own divider, usable without any prescaler.
        tdt_div u_div (
            .clk_sys(clk_sys),
            .rst_n(rst_n),
            .tick_in(tclk_en),
            .ratio(ctrl[tdt_pkg::CTRL_DIV_HI:tdt_pkg::CTRL_DIV_LO]),
            .tick_out(div_tick)
        );

        // Source select: 0x own divider, 10 prescaler 0, 11 prescaler 1.
        // A prescaler output is shared, so two channels on one prescaler step together.
        assign tick = src[1] ? ps_tick[src[0]] : div_tick;

        // Address decode for this channel.
        // Count and status writes match no select, so they are dropped quietly.
        assign wr_load = wr_en && (addr == BASE + tdt_pkg::OFF_LOAD);
        assign wr_ctrl = wr_en && (addr == BASE + tdt_pkg::OFF_CTRL);
        assign wr_clr = wr_en && (addr == BASE + tdt_pkg::OFF_CLR);
        assign wr_port = wr_en && (addr == BASE + tdt_pkg::OFF_PORT);

        // Single mode always loads at once; cyclic only with the immediate bit.
        // In cyclic mode without it the value waits in load for the next
        // underflow, so software can change the period without a glitch.
        assign force_load = wr_load && (single || ctrl[tdt_pkg::CTRL_IMM]);

        // Count only while enabled and not stopped after a single-mode run.
        // Underflow is the step taken at count zero, so a period is load plus one
        // steps. After reset the count is zero, so enabling with no load underflows at once.
        assign step = tick && ctrl[tdt_pkg::CTRL_EN] && !halted;
        assign uf = step && (cnt == 16'h0000);

        // Control and port registers; unused bits read zero.
        // A load write never touches the counter here; the counter process decides.
        always_ff @(posedge clk_sys) begin
            if (!rst_n) begin
                ctrl <= tdt_pkg::RST_REG;
                port <= tdt_pkg::RST_REG;
                load <= tdt_pkg::RST_REG;
            end else begin
                if (wr_ctrl) begin
                    ctrl <= wr_data & tdt_pkg::CTRL_MASK;
                end
                if (wr_port) begin
                    port <= wr_data & tdt_pkg::PORT_MASK;
                end
                if (wr_load) begin
                    load <= wr_data;
                end
            end
        end

        // Down counter. A forced load ignores the enable bit and also lifts
        // a single-mode halt; it wins over a count step in the same cycle.
        // In single mode the halt keeps the count at zero until software loads
        // again; clearing the flag alone does not restart it.
        always_ff @(posedge clk_sys) begin
            if (!rst_n) begin
                cnt <= 16'h0000;
                halted <= 1'b0;
            end else if (force_load) begin
                cnt <= wr_data;
                halted <= 1'b0;
            end else if (uf) begin
                if (single) begin
                    halted <= 1'b1;
                end else begin
                    cnt <= load;
                end
            end else if (step) begin
                cnt <= cnt - 16'h0001;
            end
        end

        // Sticky flag: set on unmasked underflow, cleared by any write to the
        // flag-clear register; a set in the same cycle keeps it set.
        // Set wins so an underflow that lands on the clear write is not lost;
        // software sees the flag again and services the channel once more.
        always_ff @(posedge clk_sys) begin
            if (!rst_n) begin
                irq_flag[i] <= 1'b0;
            end else if (uf && ctrl[tdt_pkg::CTRL_IRQEN]) begin
                irq_flag[i] <= 1'b1;
            end else if (wr_clr) begin
                irq_flag[i] <= 1'b0;
            end
        end

        // Underflow level lasts until the next count step; toggle flips per underflow.
        // The toggle state survives a mode change, so switching into toggle mode
        // may start from either level.
        always_ff @(posedge clk_sys) begin
            if (!rst_n) begin
                uf_level <= 1'b0;
                tog <= 1'b0;
            end else begin
                if (uf) begin
                    uf_level <= 1'b1;
                    tog <= !tog;
                end else if (step) begin
                    uf_level <= 1'b0;
                end
            end
        end

        // Pin value by output mode; the reserved code drives low.
        // Driving low rather than repeating another mode means a stray code
        // cannot make the pin look alive.
        always_comb begin
            case (omode)
                tdt_pkg::OMODE_VALUE: next_pin = port[tdt_pkg::PORT_VAL];
                tdt_pkg::OMODE_PULSE: next_pin = uf_level;
                tdt_pkg::OMODE_TOGGLE: next_pin = tog;
                default: next_pin = 1'b0;
            endcase
        end

        // Pin outputs come from flip-flops; the enable follows its bit.
        // A disabled pin reads low as well, which keeps the value and its enable
        // consistent for whoever merges them at the pad.
        always_ff @(posedge clk_sys) begin
            if (!rst_n) begin
                timer_out[i] <= 1'b0;
                timer_out_en[i] <= 1'b0;
            end else begin
                timer_out[i] <= port[tdt_pkg::PORT_OE] ? next_pin : 1'b0;
                timer_out_en[i] <= port[tdt_pkg::PORT_OE];
            end
        end

        // Read decode; the flag-clear register is write-only and reads zero.
        // Reads have no side effects; polling the count or status never disturbs it.
        assign ch_hit[i] = (addr == BASE + tdt_pkg::OFF_LOAD) || (addr == BASE + tdt_pkg::OFF_COUNT) ||
                           (addr == BASE + tdt_pkg::OFF_CTRL) || (addr == BASE + tdt_pkg::OFF_CLR) ||
                           (addr == BASE + tdt_pkg::OFF_PORT);
        assign ch_rdata[i] = (addr == BASE + tdt_pkg::OFF_LOAD) ? load :
                             (addr == BASE + tdt_pkg::OFF_COUNT) ? cnt :
                             (addr == BASE + tdt_pkg::OFF_CTRL) ? ctrl :
                             (addr == BASE + tdt_pkg::OFF_PORT) ? port : 16'h0000;
    end

    // Shared registers: prescalers and the read-only status.
    // The status holds the flags only; masked channels never set theirs.
    assign com_hit = (addr == tdt_pkg::OFF_PS0) || (addr == tdt_pkg::OFF_PS1) || (addr == tdt_pkg::OFF_STS);
    assign com_rdata = (addr == tdt_pkg::OFF_PS0) ? ps_ctrl[0] :
                       (addr == tdt_pkg::OFF_PS1) ? ps_ctrl[1] :
                       (addr == tdt_pkg::OFF_STS) ? {13'h0000, irq_flag} : 16'h0000;

    // At most one source answers; unmapped addresses read zero.
    // An OR of gated sources keeps the path short compared with a priority chain.
    assign next_rd_data = (ch_hit[0] ? ch_rdata[0] : 16'h0000) | (ch_hit[1] ? ch_rdata[1] : 16'h0000) |
                          (ch_hit[2] ? ch_rdata[2] : 16'h0000) | (com_hit ? com_rdata : 16'h0000);

    // Read data stand only in the cycle after the read strobe.
    // Clearing it otherwise lets a bus that ORs several slaves share one return path.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rd_data <= 16'h0000;
        end else if (rd_en) begin
            rd_data <= next_rd_data;
        end else begin
            rd_data <= 16'h0000;
        end
    end
endmodule

/* core/tdt_pkg.sv */
// Package for the three-channel down timer: register offsets, field positions,
// masks, reset values and the timer input clock ratio.
// Assumes a byte-addressed register port with 8-bit address and 16-bit data.
package tdt_pkg;
    // Timer input clock is the bus clock divided by this figure.
    localparam int TCLK_DIV = 8;
    localparam logic [2:0] TCLK_LAST = 3'(TCLK_DIV - 1);

    // Number of channels and register geometry.
    localparam int NCH = 3;
    localparam logic [7:0] CH_STRIDE = 8'h20;
    localparam logic [7:0] OFF_LOAD = 8'h00;
    localparam logic [7:0] OFF_COUNT = 8'h04;
    localparam logic [7:0] OFF_CTRL = 8'h08;
    localparam logic [7:0] OFF_CLR = 8'h0C;
    localparam logic [7:0] OFF_PORT = 8'h10;
    localparam logic [7:0] OFF_PS0 = 8'hA0;
    localparam logic [7:0] OFF_PS1 = 8'hA4;
    localparam logic [7:0] OFF_STS = 8'hB0;

    // Channel control fields.
    localparam int CTRL_SRC_HI = 9;
    localparam int CTRL_SRC_LO = 8;
    localparam int CTRL_EN = 7;
    localparam int CTRL_MODE = 5;
    localparam int CTRL_DIV_HI = 4;
    localparam int CTRL_DIV_LO = 2;
    localparam int CTRL_IMM = 1;
    localparam int CTRL_IRQEN = 0;
    localparam logic [15:0] CTRL_MASK = 16'h03BF;

    // Port output control fields.
    localparam int PORT_OMODE_HI = 3;
    localparam int PORT_OMODE_LO = 2;
    localparam int PORT_OE = 1;
    localparam int PORT_VAL = 0;
    localparam logic [15:0] PORT_MASK = 16'h000F;

    // Prescaler control fields.
    localparam int PS_DIV_HI = 15;
    localparam int PS_DIV_LO = 13;
    localparam int PS_LOAD_HI = 7;
    localparam int PS_LOAD_LO = 0;
    localparam logic [15:0] PS_MASK = 16'hE0FF;

    // Output mode codes.
    localparam logic [1:0] OMODE_VALUE = 2'h0;
    localparam logic [1:0] OMODE_PULSE = 2'h1;
    localparam logic [1:0] OMODE_TOGGLE = 2'h2;

    // Reset values.
    localparam logic [15:0] RST_REG = 16'h0000;
endpackage

/* core/tdt_div.sv */
// Power-of-two divider: passes one of every 1, 4, 8 ... 256 input tick pulses.
// Assumes tick_in is a one-cycle enable on clk_sys.
`timescale 1ns/1ps

module tdt_div (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic tick_in,
    input wire logic [2:0] ratio,
    output logic tick_out
);
    // Free-running count of input ticks; low bits select the ratio.
    logic [7:0] cnt;
    // Bits of cnt that must all be one for a tick to pass.
    logic [7:0] mask;

    // Code 000 passes every tick, code k above it divides by 2 to the k+1.
    always_comb begin
        case (ratio)
            3'h0: mask = 8'h00;
            3'h1: mask = 8'h03;
            3'h2: mask = 8'h07;
            3'h3: mask = 8'h0F;
            3'h4: mask = 8'h1F;
            3'h5: mask = 8'h3F;
            3'h6: mask = 8'h7F;
            default: mask = 8'hFF;
        endcase
    end

    // A ratio change mid-count only shortens or lengthens one period.
    assign tick_out = tick_in && ((cnt & mask) == mask);

    // Count input ticks.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cnt <= 8'h00;
        end else if (tick_in) begin
            cnt <= cnt + 8'h01;
        end
    end
endmodule

/* verif/tdt_top_asserts.sv */
// Checker for the three-channel down timer: read-back fields, status and pins.
// Assumes it is bound to tdt_top and sees only that module's ports.
`timescale 1ns/1ps
module tdt_checker (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [7:0] addr,
    input wire logic [15:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [15:0] rd_data,
    input wire logic [2:0] timer_out,
    input wire logic [2:0] timer_out_en
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic rd_q; // Read strobe of the previous cycle.
    logic [7:0] ra_q; // Address of that read.
    logic [2:0] seen; // Status bits seen set and not cleared since.
    wire sts_rsp = rd_q && ra_q == tdt_pkg::OFF_STS; // Status answer is on rd_data.
    wire [2:0] clr_vec = {3{wr_en}} & {addr == 8'h4C, addr == 8'h2C, addr == 8'h0C}; // Flag-clear writes.
    wire [2:0] next_seen = (sts_rsp ? rd_data[2:0] : seen) & ~clr_vec; // A clear drops a bit.

    // Short bookkeeping so a status bit can be tied to the writes that clear it.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rd_q <= 1'b0;
            ra_q <= 8'h00;
            seen <= 3'h0;
        end else begin
            rd_q <= rd_en;
            ra_q <= addr;
            seen <= next_seen;
        end
    end

    a_pin_gated: assert property ((timer_out & ~timer_out_en) == 3'h0)
        else $error("pin driven while its enable is low");
    a_oe_follow: assert property (wr_en && addr == 8'h10 |-> ##2 timer_out_en[0] == $past(wr_data[1], 2))
        else $error("pin enable does not follow the port control write");
    a_value_drive: assert property (wr_en && addr == 8'h10 && wr_data[3:1] == 3'h1 |->
        ##2 timer_out[0] == $past(wr_data[0], 2))
        else $error("value mode does not drive the value bit");
    a_ps_fields: assert property (rd_q && (ra_q == 8'hA0 || ra_q == 8'hA4) |->
        (rd_data & ~tdt_pkg::PS_MASK) == 16'h0000)
        else $error("prescaler read shows unused bits");
    a_ps_back: assert property (wr_en && addr == 8'hA0 ##2 rd_en && addr == 8'hA0 |->
        ##1 rd_data == ($past(wr_data, 3) & tdt_pkg::PS_MASK))
        else $error("prescaler read-back differs from the write");
    a_sts_reserved: assert property (sts_rsp |-> rd_data[15:3] == 13'h0000)
        else $error("status shows bits above channel two");
    a_sts_sticky: assert property (sts_rsp |-> (rd_data[2:0] & seen) == seen)
        else $error("status bit fell without a clear write");
    a_ctrl_fields: assert property (rd_q && ra_q[4:0] == 5'h08 && ra_q < 8'h60 |->
        (rd_data & ~tdt_pkg::CTRL_MASK) == 16'h0000)
        else $error("control read shows unused bits");
    a_clr_zero: assert property (rd_q && ra_q[4:0] == 5'h0C && ra_q < 8'h60 |-> rd_data == 16'h0000)
        else $error("flag-clear register reads nonzero");
endmodule

bind tdt_top tdt_checker chk_u (.clk_sys(clk_sys), .rst_n(rst_n), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .timer_out(timer_out), .timer_out_en(timer_out_en));

/* verif/test_tdt_top.sv */
// Self-checking bench for the three-channel down timer.
// Assumes the checker is bound separately; the bench drives the register port.
`timescale 1ns/1ps
module test_tdt_top;
    typedef struct {logic [15:0] v; bit on; string nm;} tdt_exp_s; // One noted read result.
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [15:0] wr_data = 16'h0000;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [15:0] rd_data;
    logic [2:0] timer_out;
    logic [2:0] timer_out_en;
    logic rd_d = 1'b0; // Read strobe one edge later: the answer stands now.
    tdt_exp_s exp_q[$]; // Notes from the driver, oldest first.
    tdt_exp_s e;
    int error_cnt = 0;
    int checks = 0;
    int cyc = 0; // Cycle count, used to time count steps.
    int per;
    logic [15:0] v;
    logic [15:0] d;

    always #12.5 clk_sys = ~clk_sys;

    tdt_top dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .timer_out(timer_out),
        .timer_out_en(timer_out_en));

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] ex);
        checks++;
        if (seen !== ex) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, ex, seen);
        end
    endtask

    // The watcher takes the oldest note for each read answer and compares the two when its on bit is set, at mid-cycle.
    always @(posedge clk_sys) begin
        rd_d <= rd_en;
        cyc <= cyc + 1;
    end
    always @(negedge clk_sys) begin
        if (rd_d) begin
            e = exp_q.pop_front();
            if (e.on) chk(e.nm, rd_data, e.v);
        end
    end

    // Writes leave a one-cycle gap so no strobe is driven twice in one step.
    task automatic wr(input logic [7:0] a, input logic [15:0] dat);
        @(posedge clk_sys);
        addr <= a;
        wr_data <= dat;
        wr_en <= 1'b1;
        @(posedge clk_sys);
        wr_en <= 1'b0;
    endtask

    // Reads note the expectation; when on is clear the answer is only returned.
    task automatic rd(input logic [7:0] a, input logic [15:0] ex, input bit on, input string nm,
        output logic [15:0] q);
        @(posedge clk_sys);
        addr <= a;
        rd_en <= 1'b1;
        exp_q.push_back('{ex, on, nm});
        @(posedge clk_sys);
        rd_en <= 1'b0;
        @(negedge clk_sys);
        q = rd_data;
    endtask

    // Polls status until bit i is set, with a bounded number of reads.
    task automatic wait_sts(input int i);
        v = 16'h0000;
        for (int n = 0; n < 600 && v[i] !== 1'b1; n++) rd(8'hB0, 16'h0000, 1'b0, "", v);
        chk("irq flag", 16'(v[i]), 16'h0001);
    endtask

    // Cycles between two count changes; the first change may come from an old setting.
    task automatic meas(input logic [7:0] a, output int p);
        int ts;
        logic [15:0] old;
        logic [15:0] q;
        ts = 0;
        p = 0;
        rd(a, 16'h0000, 1'b0, "", old);
        for (int k = 0; k < 2400 && p == 0; k++) begin
            rd(a, 16'h0000, 1'b0, "", q);
            if (q !== old) begin
                if (ts != 0) p = cyc - ts;
                ts = cyc;
                old = q;
            end
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // A hang is cut off at 60000 cycles, several times the expected run.
    initial begin
        repeat (60000) @(posedge clk_sys);
        error_cnt++;
        report_and_stop();
    end

    initial begin
        void'($urandom(32851));
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(8'hB0, 16'h0000, 1'b1, "status reset", v);
        rd(8'h08, 16'h0000, 1'b1, "ctrl0 reset", v);
        rd(8'h2C, 16'h0000, 1'b1, "clear reg", v);
        wr(8'hB0, 16'hFFFF);
        rd(8'hB0, 16'h0000, 1'b1, "status ro", v);
        for (int k = 0; k < 4; k++) begin
            d = 16'($urandom());
            wr(8'hA0, d);
            rd(8'hA0, d & tdt_pkg::PS_MASK, 1'b1, "ps0 fields", v);
        end
        $display("test registers done");
        // Value mode on channel 0, then the enable taken away.
        for (int k = 0; k < 3; k++) begin
            wr(8'h10, k == 2 ? 16'h0001 : 16'h0002 | 16'(k));
            repeat (3) @(negedge clk_sys);
            chk("pin0 oe", 16'(timer_out_en[0]), 16'(k != 2));
            chk("pin0 val", 16'(timer_out[0]), 16'(k == 1));
        end
        $display("test pins done");
        // Free-running channel 0, timed at every divider code.
        wr(8'h08, 16'h0002);
        wr(8'h00, 16'hFFFF);
        rd(8'h04, 16'hFFFF, 1'b1, "forced load", v);
        for (int k = 0; k < 8; k++) begin
            wr(8'h08, 16'h0080 | 16'(k << 2));
            meas(8'h04, per);
            chk("div period", 16'(per), 16'(8 * (k == 0 ? 1 : 2 << k)));
        end
        wr(8'h08, 16'h0000);
        wr(8'h28, 16'h0002);
        wr(8'h20, 16'hFFFF);
        wr(8'hA0, 16'h0002);
        wr(8'h28, 16'h0280);
        meas(8'h24, per);
        chk("ps0 period", 16'(per), 16'd24);
        wr(8'hA4, 16'h2001);
        wr(8'h28, 16'h0380);
        meas(8'h24, per);
        chk("ps1 period", 16'(per), 16'd64);
        $display("test dividers done");
        // Deferred load in cyclic mode: stored, then used at underflow.
        wr(8'h28, 16'h0002);
        wr(8'h20, 16'h0003);
        wr(8'h28, 16'h0081);
        wr(8'h20, 16'h0006);
        rd(8'h24, 16'h0000, 1'b0, "", v);
        chk("deferred", 16'(v <= 16'h0003), 16'h0001);
        wait_sts(1);
        rd(8'h24, 16'h0000, 1'b0, "", v);
        chk("reload", 16'(v >= 16'h0005 && v <= 16'h0006), 16'h0001);
        rd(8'hB0, 16'h0002, 1'b1, "sticky", v);
        wr(8'h2C, 16'h0000);
        rd(8'hB0, 16'h0000, 1'b1, "cleared", v);
        wr(8'h28, 16'h0080);
        repeat (80) @(negedge clk_sys);
        rd(8'hB0, 16'h0000, 1'b1, "masked", v);
        wr(8'h28, 16'h0000);
        $display("test cyclic done");
        // Single mode on channel 2 with the toggle pin.
        wr(8'h50, 16'h000A);
        wr(8'h48, 16'h0021);
        wr(8'h40, 16'h0002);
        rd(8'h44, 16'h0002, 1'b1, "single load", v);
        wr(8'h48, 16'h00A1);
        wait_sts(2);
        rd(8'h44, 16'h0000, 1'b1, "halted", v);
        chk("toggle on", 16'(timer_out[2]), 16'h0001);
        wr(8'h4C, 16'h0000);
        repeat (40) @(negedge clk_sys);
        rd(8'h44, 16'h0000, 1'b1, "stays halted", v);
        rd(8'hB0, 16'h0000, 1'b1, "flag cleared", v);
        wr(8'h40, 16'h0001);
        wait_sts(2);
        chk("toggle off", 16'(timer_out[2]), 16'h0000);
        $display("test single done");
        // Pulse and reserved pin modes on channel 0 around a single-mode halt.
        wr(8'h10, 16'h0006);
        wr(8'h08, 16'h0021);
        wr(8'h00, 16'h0001);
        wr(8'h08, 16'h00A1);
        wait_sts(0);
        chk("pulse on", 16'(timer_out[0]), 16'h0001);
        wr(8'h00, 16'h0003);
        repeat (12) @(negedge clk_sys);
        chk("pulse off", 16'(timer_out[0]), 16'h0000);
        wr(8'h10, 16'h000F);
        repeat (3) @(negedge clk_sys);
        chk("reserved low", 16'(timer_out[0]), 16'h0000);
        $display("test pulse done");
        report_and_stop();
    end
endmodule
